// >>> rtl/fcs_bus_cycle.sv
/*
  Runs one read or write cycle on the flash pins: setup, strobe, hold.
  Assumes start is only raised while the engine is idle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcs_cfg.svh"

module fcs_bus_cycle #(
  parameter int SETUP_CYC = `FCS_SETUP_CYC,
  parameter int PULSE_CYC = `FCS_PULSE_CYC,
  parameter int HOLD_CYC = `FCS_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire fcs_pkg::fcs_cyc_t cyc,
  output logic done,
  output logic [15:0] rdata,
  output logic [20:0] fl_addr,
  input wire logic [15:0] fl_rd_data,
  output logic [15:0] fl_wr_data,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  import fcs_pkg::*;

  if (SETUP_CYC < 1 || SETUP_CYC > 256 || PULSE_CYC < 1 ||
      PULSE_CYC > 256 || HOLD_CYC < 1 || HOLD_CYC > 256) begin : g_chk
    $error("fcs_bus_cycle: phase counts must lie in 1..256");
  end

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_PULSE, B_HOLD} fcs_bstate_t;

  fcs_bstate_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  logic done_ff, nxt_done;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [20:0] addr_ff, nxt_addr;
  logic [15:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe;
  logic ce_n_ff, nxt_ce_n;
  logic we_n_ff, nxt_we_n;
  logic oe_n_ff, nxt_oe_n;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_addr = addr_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    case (state_ff)
      B_IDLE: begin
        if (start) begin
          // Address is settled in the same cycle chip enable falls, before the write or read strobe falls.
          nxt_addr = cyc.addr;
          nxt_dq = cyc.data;
          nxt_dq_oe = cyc.wr;
          nxt_wr = cyc.wr;
          nxt_ce_n = 1'b0;
          nxt_cnt = 8'(SETUP_CYC - 1);
          nxt_state = B_SETUP;
        end
      end
      B_SETUP: begin
        if (cnt_ff == 8'h00) begin
          // Output enable stays high for writes so none reads as a read.
          nxt_we_n = ~wr_ff;
          nxt_oe_n = wr_ff;
          nxt_cnt = 8'(PULSE_CYC - 1);
          nxt_state = B_PULSE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      B_PULSE: begin
        if (cnt_ff == 8'h00) begin
          if (!wr_ff) begin
            nxt_rdata = fl_rd_data;
          end
          nxt_we_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cnt = 8'(HOLD_CYC - 1);
          nxt_state = B_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      B_HOLD: begin
        // Data stays driven past the write strobe's rising edge.
        if (cnt_ff == 8'h00) begin
          nxt_ce_n = 1'b1;
          nxt_dq_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_state = B_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_state = B_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= B_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_ff <= 21'h000000;
      dq_ff <= 16'h0000;
      dq_oe_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
      addr_ff <= nxt_addr;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign done = done_ff;
  assign rdata = rdata_ff;
  assign fl_addr = addr_ff;
  assign fl_wr_data = dq_ff;
  assign fl_dq_oe = dq_oe_ff;
  assign fl_ce_n = ce_n_ff;
  assign fl_we_n = we_n_ff;
  assign fl_oe_n = oe_n_ff;

endmodule : fcs_bus_cycle

`default_nettype wire

// >>> rtl/fcs_cfg.svh
/*
  Constants for the flash command sequencer: unlock addresses, command
  codes, status bit positions and bus cycle timing.
  Assumes a 20 MHz REF_CLK and a flash with 21 address and 16 data lines.
*/
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

`define FCS_CLK_NS 50
`define FCS_T_SETUP_NS 50
`define FCS_T_PULSE_NS 100
`define FCS_T_HOLD_NS 50
`define FCS_SETUP_CYC ((`FCS_T_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_PULSE_CYC ((`FCS_T_PULSE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_HOLD_CYC ((`FCS_T_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`define FCS_A_U1_WORD 21'h000555
`define FCS_A_U2_WORD 21'h0002AA
`define FCS_A_U1_BYTE 21'h000AAA
`define FCS_A_U2_BYTE 21'h000555
`define FCS_A_CFI_WORD 21'h000055
`define FCS_A_CFI_BYTE 21'h0000AA
`define FCS_A_ANY 21'h000000

`define FCS_D_UNLOCK1 16'h00AA
`define FCS_D_UNLOCK2 16'h0055
`define FCS_D_PROGRAM 16'h00A0
`define FCS_D_BYPASS 16'h0020
`define FCS_D_AUTOSEL 16'h0090
`define FCS_D_BYP_EXIT2 16'h0000
`define FCS_D_ERASE_SETUP 16'h0080
`define FCS_D_CHIP_ERASE 16'h0010
`define FCS_D_SECT_ERASE 16'h0030
`define FCS_D_SUSPEND 16'h00B0
`define FCS_D_RESUME 16'h0030
`define FCS_D_CFI 16'h0098
`define FCS_D_RESET 16'h00F0

`define FCS_BIT_ERROR 5
`define FCS_BIT_TOGGLE 6

`endif

// >>> rtl/fcs_pkg.sv
/*
  Types shared by the flash command sequencer and its bus cycle engine.
  Assumes fcs_cfg.svh for all numeric constants.
*/
`default_nettype none

package fcs_pkg;

  typedef enum logic [3:0] {
    OP_READ, OP_ID_READ, OP_RESET, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG,
    OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SUSPEND, OP_RESUME,
    OP_AUTOSEL, OP_CFI
  } fcs_op_t;

  typedef enum logic [1:0] {
    MODE_ARRAY, MODE_AUTOSEL, MODE_CFI, MODE_BYPASS
  } fcs_mode_t;

  typedef struct packed {
    fcs_op_t op;
    logic [20:0] addr;
    logic [15:0] data;
  } fcs_req_t;

  typedef struct packed {
    logic wr;
    logic [20:0] addr;
    logic [15:0] data;
  } fcs_cyc_t;

  typedef struct packed {
    logic last;
    fcs_cyc_t cyc;
  } fcs_step_t;

endpackage : fcs_pkg

`default_nettype wire

// >>> rtl/fcs_sequencer.sv
/*
  Host-side flash command sequencer: turns one user request into the
  unlock/command write cycles and reads that a parallel NOR flash expects.
  Assumes the flash pins are synchronous to REF_CLK and that the bench
  resolves the data bus from FL_DQ_OE.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcs_cfg.svh"

module fcs_sequencer (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire fcs_pkg::fcs_req_t REQ,
  input wire logic BYTE_MODE,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic ERR_FLAG,
  output logic [1:0] MODE,
  output logic BUSY,
  output logic [20:0] FL_ADDR,
  input wire logic [15:0] FL_RD_DATA,
  output logic [15:0] FL_WR_DATA,
  output logic FL_DQ_OE,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} fcs_mstate_t;

  fcs_mstate_t state_ff, nxt_state;
  fcs_req_t req_ff, nxt_req;
  logic [2:0] step_ff, nxt_step;
  logic bm_ff, nxt_bm;
  logic pre_ff, nxt_pre;
  fcs_mode_t mode_ff, nxt_mode;
  logic busy_ff, nxt_busy;
  logic tog_ff, nxt_tog, tog_v_ff, nxt_tog_v;
  logic err_ff, nxt_err;
  logic rsp_v_ff, nxt_rsp_v;
  logic [15:0] rsp_d_ff, nxt_rsp_d;
  fcs_step_t entry;
  logic cyc_start, cyc_done, err_hit;
  logic [15:0] cyc_rdata;

  // Builds the bus cycle for one step of the latched operation.
  function automatic fcs_step_t seq_entry(fcs_op_t op, logic [2:0] st,
                                          logic bm, logic pre,
                                          fcs_req_t r);
    fcs_step_t s;
    logic [20:0] u1;
    logic [20:0] u2;
    logic [15:0] cmd3;
    u1 = bm ? `FCS_A_U1_BYTE : `FCS_A_U1_WORD;
    u2 = bm ? `FCS_A_U2_BYTE : `FCS_A_U2_WORD;
    cmd3 = (op == OP_PROGRAM) ? `FCS_D_PROGRAM :
           (op == OP_BYP_ENTER) ? `FCS_D_BYPASS :
           (op == OP_AUTOSEL) ? `FCS_D_AUTOSEL : `FCS_D_ERASE_SETUP;
    s = '{last: 1'b1, cyc: '{wr: 1'b1, addr: `FCS_A_ANY,
                             data: `FCS_D_RESET}};
    case (op)
      OP_READ: begin
        // Leaving autoselect or query needs a reset write first.
        s.last = pre && (st == 3'h0) ? 1'b0 : 1'b1;
        if (!(pre && st == 3'h0)) begin
          s.cyc = '{wr: 1'b0, addr: r.addr, data: 16'h0000};
        end
      end
      OP_ID_READ: s.cyc = '{wr: 1'b0, addr: r.addr, data: 16'h0000};
      OP_PROGRAM, OP_BYP_ENTER, OP_AUTOSEL, OP_CHIP_ERASE,
      OP_SECT_ERASE: begin
        s.last = 1'b0;
        case (st)
          3'h0: s.cyc = '{wr: 1'b1, addr: u1, data: `FCS_D_UNLOCK1};
          3'h1: s.cyc = '{wr: 1'b1, addr: u2, data: `FCS_D_UNLOCK2};
          3'h2: begin
            s.cyc = '{wr: 1'b1, addr: u1, data: cmd3};
            s.last = (op == OP_BYP_ENTER) || (op == OP_AUTOSEL);
          end
          3'h3: begin
            if (op == OP_PROGRAM) begin
              s.cyc = '{wr: 1'b1, addr: r.addr, data: r.data};
              s.last = 1'b1;
            end else begin
              s.cyc = '{wr: 1'b1, addr: u1, data: `FCS_D_UNLOCK1};
            end
          end
          3'h4: s.cyc = '{wr: 1'b1, addr: u2, data: `FCS_D_UNLOCK2};
          default: begin
            s.last = 1'b1;
            if (op == OP_CHIP_ERASE) begin
              s.cyc = '{wr: 1'b1, addr: u1, data: `FCS_D_CHIP_ERASE};
            end else begin
              s.cyc = '{wr: 1'b1, addr: r.addr,
                        data: `FCS_D_SECT_ERASE};
            end
          end
        endcase
      end
      OP_BYP_PROG: begin
        s.last = (st != 3'h0);
        s.cyc = (st == 3'h0) ?
                '{wr: 1'b1, addr: `FCS_A_ANY, data: `FCS_D_PROGRAM} :
                '{wr: 1'b1, addr: r.addr, data: r.data};
      end
      OP_BYP_EXIT: begin
        s.last = (st != 3'h0);
        s.cyc.data = (st == 3'h0) ? `FCS_D_AUTOSEL : `FCS_D_BYP_EXIT2;
      end
      OP_SUSPEND: s.cyc.data = `FCS_D_SUSPEND;
      OP_RESUME: s.cyc.data = `FCS_D_RESUME;
      OP_CFI: s.cyc = '{wr: 1'b1,
                        addr: bm ? `FCS_A_CFI_BYTE : `FCS_A_CFI_WORD,
                        data: `FCS_D_CFI};
      default: s.cyc.data = `FCS_D_RESET;
    endcase
    return s;
  endfunction : seq_entry

  always_comb begin
    entry = seq_entry(req_ff.op, step_ff, bm_ff, pre_ff, req_ff);
  end

  assign cyc_start = (state_ff == M_ISSUE);
  // A status poll showing the error bit while an algorithm runs.
  assign err_hit = (state_ff == M_WAIT) && cyc_done && entry.last &&
                   !entry.cyc.wr && busy_ff && cyc_rdata[`FCS_BIT_ERROR];

  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_step = step_ff;
    nxt_bm = bm_ff;
    nxt_pre = pre_ff;
    nxt_mode = mode_ff;
    nxt_busy = busy_ff;
    nxt_tog = tog_ff;
    nxt_tog_v = tog_v_ff;
    nxt_err = err_ff;
    nxt_rsp_v = 1'b0;
    nxt_rsp_d = rsp_d_ff;
    case (state_ff)
      M_IDLE: begin
        if (REQ_VALID) begin
          nxt_req = REQ;
          nxt_bm = BYTE_MODE;
          nxt_pre = (mode_ff == MODE_AUTOSEL) || (mode_ff == MODE_CFI);
          nxt_step = 3'h0;
          nxt_err = 1'b0;
          nxt_state = M_ISSUE;
        end
      end
      M_ISSUE: nxt_state = M_WAIT;
      M_WAIT: begin
        if (cyc_done && !entry.last) begin
          nxt_step = step_ff + 3'h1;
          nxt_state = M_ISSUE;
        end else if (cyc_done) begin
          nxt_state = M_IDLE;
          nxt_rsp_v = 1'b1;
          nxt_rsp_d = entry.cyc.wr ? 16'h0000 : cyc_rdata;
          nxt_tog_v = !entry.cyc.wr;
          if (!entry.cyc.wr) begin
            nxt_tog = cyc_rdata[`FCS_BIT_TOGGLE];
            // Two polls after the start must agree; an older bit is stale.
            if (busy_ff && tog_v_ff &&
                tog_ff == cyc_rdata[`FCS_BIT_TOGGLE]) begin
              nxt_busy = 1'b0;
            end
          end
          case (req_ff.op)
            OP_READ, OP_RESET, OP_BYP_EXIT: nxt_mode = MODE_ARRAY;
            OP_AUTOSEL: nxt_mode = MODE_AUTOSEL;
            OP_CFI: nxt_mode = MODE_CFI;
            OP_BYP_ENTER: nxt_mode = MODE_BYPASS;
            OP_PROGRAM, OP_BYP_PROG, OP_CHIP_ERASE, OP_SECT_ERASE,
            OP_RESUME: nxt_busy = 1'b1;
            OP_SUSPEND: nxt_busy = 1'b0;
            default: nxt_mode = mode_ff;
          endcase
          if (req_ff.op == OP_RESET) begin
            nxt_busy = 1'b0;
          end
          if (err_hit) begin
            // A reset write is chained straight after the failing poll.
            nxt_err = 1'b1;
            nxt_req.op = OP_RESET;
            nxt_step = 3'h0;
            nxt_rsp_v = 1'b0;
            nxt_state = M_ISSUE;
          end
        end
      end
      default: nxt_state = M_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_ff <= M_IDLE;
      req_ff <= '{op: OP_READ, addr: 21'h000000, data: 16'h0000};
      step_ff <= 3'h0;
      bm_ff <= 1'b0;
      pre_ff <= 1'b0;
      mode_ff <= MODE_ARRAY;
      busy_ff <= 1'b0;
      tog_ff <= 1'b0;
      tog_v_ff <= 1'b0;
      err_ff <= 1'b0;
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      step_ff <= nxt_step;
      bm_ff <= nxt_bm;
      pre_ff <= nxt_pre;
      mode_ff <= nxt_mode;
      busy_ff <= nxt_busy;
      tog_ff <= nxt_tog;
      tog_v_ff <= nxt_tog_v;
      err_ff <= nxt_err;
      rsp_v_ff <= nxt_rsp_v;
      rsp_d_ff <= nxt_rsp_d;
    end
  end

  fcs_bus_cycle u_cycle (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .start(cyc_start),
    .cyc(entry.cyc),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(FL_ADDR),
    .fl_rd_data(FL_RD_DATA),
    .fl_wr_data(FL_WR_DATA),
    .fl_dq_oe(FL_DQ_OE),
    .fl_ce_n(FL_CE_N),
    .fl_we_n(FL_WE_N),
    .fl_oe_n(FL_OE_N)
  );

  assign REQ_READY = (state_ff == M_IDLE);
  assign RSP_VALID = rsp_v_ff;
  assign RSP_DATA = rsp_d_ff;
  assign ERR_FLAG = err_ff;
  assign MODE = mode_ff;
  assign BUSY = busy_ff;

  default clocking cb_ref @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_write_in_seq: assert property (
    (!FL_WE_N && $past(FL_WE_N)) |-> (state_ff == M_WAIT) && FL_OE_N &&
    !FL_CE_N && FL_DQ_OE)
    else $error("write strobe outside a command sequence");

  a_prog_unlock: assert property (
    (cyc_start && req_ff.op == OP_PROGRAM && step_ff == 3'h0) |=>
    FL_WR_DATA == `FCS_D_UNLOCK1 &&
    FL_ADDR == (bm_ff ? `FCS_A_U1_BYTE : `FCS_A_U1_WORD))
    else $error("program sequence does not open with the first unlock");

  a_bypass_exit: assert property (
    (cyc_start && req_ff.op == OP_BYP_EXIT && step_ff == 3'h1) |=>
    FL_DQ_OE && FL_WR_DATA == `FCS_D_BYP_EXIT2 && $past(step_ff, 1) == 3'h1)
    else $error("bypass exit second write is not 00");

  a_sector_pick: assert property (
    (cyc_start && req_ff.op == OP_SECT_ERASE && step_ff == 3'h5) |=>
    FL_WR_DATA == `FCS_D_SECT_ERASE && FL_ADDR[20:12] == req_ff.addr[20:12])
    else $error("sector erase command not aimed at the chosen sector");

  a_chip_final: assert property (
    (cyc_start && req_ff.op == OP_CHIP_ERASE && step_ff == 3'h5) |=>
    FL_WR_DATA == `FCS_D_CHIP_ERASE &&
    FL_ADDR == (bm_ff ? `FCS_A_U1_BYTE : `FCS_A_U1_WORD))
    else $error("chip erase command wrong");

  a_autosel_mode: assert property (
    (cyc_done && state_ff == M_WAIT && req_ff.op == OP_AUTOSEL &&
     step_ff == 3'h2) |=> mode_ff == MODE_AUTOSEL && RSP_VALID)
    else $error("autoselect entry not recorded");

  a_query_entry: assert property (
    (cyc_start && req_ff.op == OP_CFI) |=> FL_DQ_OE &&
    FL_WR_DATA == `FCS_D_CFI &&
    FL_ADDR == (bm_ff ? `FCS_A_CFI_BYTE : `FCS_A_CFI_WORD))
    else $error("query entry write wrong");

  a_error_reset: assert property (
    err_hit |-> ##[1:60] (!FL_WE_N && FL_WR_DATA == `FCS_D_RESET))
    else $error("no reset write after timeout error");

endmodule : fcs_sequencer

`default_nettype wire

// >>> verif/fcs_flash_model.sv
/*
  Pin-level behavioural model of the parallel flash command decoder.
  Assumes pins change only just after REF_CLK rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
  parameter logic [15:0] MFR_ID = 16'h00A5, // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h0B3C, // Arbitrary value.
  parameter logic [15:0] SUSP_STAT = 16'h0088,
  parameter int BUSY_READS = 3
) (
  input wire logic clk,
  input wire logic powered,
  input wire logic byte_mode,
  input wire logic fail_next,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n
);
  typedef enum {READ, IDENT, QUERY, BYP, RUN, SUSP} fcs_fm_st_t;
  fcs_fm_st_t st = READ;
  fcs_fm_st_t ret = READ;
  logic [15:0] mem [int];
  logic [15:0] rv, wd;
  logic [15:0] last = 16'h0000;
  logic [20:0] wa, u1, u2;
  logic [8:0] sec;
  logic pend = 1'b0, rd_prev = 1'b0, err = 1'b0, tog = 1'b0, ers = 1'b0;
  int step = 0;
  int left = 0;
  assign u1 = byte_mode ? 21'h000AAA : 21'h000555;
  assign u2 = byte_mode ? 21'h000555 : 21'h0002AA;
  // A released bus shows the inverse of its last value, never a held copy.
  assign dq_out = (!ce_n && !oe_n) ? rv : ~last;
  always @* begin
    rv = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    case (st)
      IDENT: case (byte_mode ? addr[7:1] : addr[6:0])
        7'h00: rv = MFR_ID;
        7'h01: rv = DEV_ID;
        default: rv = 16'h0000;
      endcase
      QUERY: rv = 16'h0051;
      RUN: rv = {9'h000, tog, err, 5'h00};
      SUSP: if (addr[20:12] == sec) rv = SUSP_STAT;
      default: ;
    endcase
  end
  task automatic run(input logic e);
    ret = (st == SUSP || st == BYP) ? st : READ;
    err = fail_next;
    ers = e;
    left = BUSY_READS;
    st = RUN;
    step = 0;
  endtask : run
  task automatic abort();
    step = 0;
    st = (st == SUSP) ? SUSP : READ;
  endtask : abort
  task automatic cmd(input logic [20:0] a, input logic [15:0] d);
    if (st == RUN) begin
      if (err && d == 16'h00F0) st = READ;
      else if (ers && d == 16'h00B0) st = SUSP;
    end else if (st == BYP) begin
      if (step == 0 && d == 16'h00A0) step = 6;
      else if (step == 0 && d == 16'h0090) step = 7;
      else if (step == 6) begin
        mem[a] = d;
        run(1'b0);
      end else if (step == 7 && d == 16'h0000) begin
        st = READ;
        step = 0;
      end else abort();
    end else if (step == 6) begin
      if (!fail_next) mem[a] = d;
      run(1'b0);
    end else if (d == 16'h00F0) abort();
    else if (step == 0 && st == SUSP && d == 16'h0030) begin
      run(1'b1);
      ret = READ;
    end else if (step == 0 && st == READ && d == 16'h0098 &&
                 a == (byte_mode ? 21'h0000AA : 21'h000055)) st = QUERY;
    else if ((step == 0 || step == 3) && a == u1 && d == 16'h00AA) step++;
    else if ((step == 1 || step == 4) && a == u2 && d == 16'h0055) step++;
    else if (step == 2 && a == u1 && d == 16'h00A0) step = 6;
    else if (step == 2 && a == u1 && st == READ && d == 16'h0020) begin
      st = BYP;
      step = 0;
    end else if (step == 2 && a == u1 && st == READ && d == 16'h0090) begin
      st = IDENT;
      step = 0;
    end else if (step == 2 && a == u1 && st == READ && d == 16'h0080) step = 3;
    else if (step == 5 && a == u1 && d == 16'h0010) begin
      mem.delete();
      run(1'b0);
    end else if (step == 5 && d == 16'h0030) begin
      sec = a[20:12];
      foreach (mem[k]) if (k[20:12] == sec) mem[k] = 16'hFFFF;
      run(1'b1);
    end else abort();
  endtask : cmd
  always @(posedge clk) begin
    if (!ce_n && !oe_n) last = rv;
    if (rd_prev && oe_n && st == RUN) begin
      tog = ~tog;
      if (!err) left--;
      if (!err && left == 0) st = ret;
    end
    rd_prev = !ce_n && !oe_n;
    if (!ce_n && !we_n && oe_n) begin
      pend = 1'b1;
      wa = addr;
      wd = dq_in;
    end else if (pend && we_n) begin
      pend = 1'b0;
      if (powered) cmd(wa, wd);
    end
  end
endmodule : fcs_flash_model
`default_nettype wire

// >>> verif/fcs_sequencer_tb.sv
/*
  Self-checking bench: the sequencer drives the flash pin model.
  Assumes fcs_pkg, the design and the model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer_tb;
  import fcs_pkg::*;
  localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h0B3C; // Arbitrary value.
  localparam logic [15:0] SST = 16'h0088;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, byte_mode = 1'b0;
  logic powered = 1'b0, fail_next = 1'b0;
  fcs_req_t req = '0;
  logic req_ready, rsp_valid, err_flag, busy, dq_oe, ce_n, we_n, oe_n;
  logic [15:0] rsp_data, dq_host, dq_flash, dq_bus, rd;
  logic [1:0] mode;
  logic [20:0] fl_addr;
  int n_fail = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  assign dq_bus = dq_oe ? dq_host : dq_flash;
  fcs_sequencer fcs_sequencer_i (.REF_CLK(clk), .SYS_RST(rst),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .BYTE_MODE(byte_mode), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .ERR_FLAG(err_flag), .MODE(mode), .BUSY(busy), .FL_ADDR(fl_addr),
    .FL_RD_DATA(dq_bus), .FL_WR_DATA(dq_host), .FL_DQ_OE(dq_oe),
    .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n));
  fcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .SUSP_STAT(SST))
    fcs_flash_model_i (.clk(clk), .powered(powered), .byte_mode(byte_mode),
    .fail_next(fail_next), .addr(fl_addr), .dq_in(dq_bus),
    .dq_out(dq_flash), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // The request is held until the edge that takes it, then dropped.
  task automatic op(input fcs_op_t o, input logic [20:0] a,
                    input logic [15:0] d);
    int i;
    int j;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: o, addr: a, data: d};
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 500);
    @(posedge clk);
    req_valid <= 1'b0;
    j = 0;
    do begin
      @(negedge clk);
      j++;
    end while (rsp_valid !== 1'b1 && j < 2000);
    if (i >= 500 || j >= 2000) begin
      n_fail++;
      $display("[FAIL] %0t: no handshake", $time);
      final_report();
    end
    rd = rsp_data;
  endtask : op
  task automatic poll(input logic [20:0] a);
    for (int i = 0; i < 30 && busy !== 1'b0; i++) op(OP_READ, a, 16'h0000);
    chk({15'h0000, busy}, 16'h0000);
  endtask : poll
  task automatic prog_chk(input logic [20:0] a, input logic [15:0] d);
    op(OP_PROGRAM, a, d);
    poll(a);
    op(OP_READ, a, 16'h0000);
    chk(rd, d);
  endtask : prog_chk
  task automatic rd_chk(input logic [20:0] a, input logic [15:0] e);
    op(OP_READ, a, 16'h0000);
    chk(rd, e);
  endtask : rd_chk
  task automatic t_powerup();
    op(OP_PROGRAM, 21'h001234, 16'h5A3C);
    poll(21'h001234);
    rd_chk(21'h001234, 16'hFFFF);
  endtask : t_powerup
  task automatic t_program();
    prog_chk(21'h001234, 16'h5A3C);
    @(posedge clk) byte_mode <= 1'b1;
    prog_chk(21'h000100, 16'h00C3);
    @(posedge clk) byte_mode <= 1'b0;
  endtask : t_program
  task automatic t_bypass();
    op(OP_BYP_ENTER, 21'h000000, 16'h0000);
    chk({14'h0000, mode}, 16'h0003);
    op(OP_BYP_PROG, 21'h002000, 16'h1357);
    poll(21'h002000);
    op(OP_BYP_PROG, 21'h002001, 16'h2468);
    poll(21'h002001);
    op(OP_BYP_EXIT, 21'h000000, 16'h0000);
    chk({14'h0000, mode}, 16'h0000);
    rd_chk(21'h002000, 16'h1357);
    rd_chk(21'h002001, 16'h2468);
  endtask : t_bypass
  task automatic t_erase();
    prog_chk(21'h005010, 16'h0A0A);
    prog_chk(21'h006010, 16'h0B0B);
    op(OP_SECT_ERASE, 21'h005000, 16'h0000);
    poll(21'h005010);
    rd_chk(21'h005010, 16'hFFFF);
    rd_chk(21'h006010, 16'h0B0B);
    op(OP_CHIP_ERASE, 21'h000000, 16'h0000);
    poll(21'h006010);
    rd_chk(21'h006010, 16'hFFFF);
  endtask : t_erase
  task automatic t_suspend();
    prog_chk(21'h007010, 16'h1111);
    prog_chk(21'h008020, 16'h2222);
    op(OP_SECT_ERASE, 21'h007000, 16'h0000);
    op(OP_SUSPEND, 21'h000000, 16'h0000);
    rd_chk(21'h007010, SST);
    rd_chk(21'h008020, 16'h2222);
    prog_chk(21'h009030, 16'h3333);
    rd_chk(21'h007010, SST);
    op(OP_RESUME, 21'h000000, 16'h0000);
    poll(21'h007010);
    rd_chk(21'h007010, 16'hFFFF);
  endtask : t_suspend
  task automatic t_ident();
    op(OP_AUTOSEL, 21'h000000, 16'h0000);
    chk({14'h0000, mode}, 16'h0001);
    op(OP_ID_READ, 21'h000000, 16'h0000);
    chk(rd, MFR);
    op(OP_ID_READ, 21'h000001, 16'h0000);
    chk(rd, DEV);
    op(OP_ID_READ, 21'h008002, 16'h0000);
    chk(rd, 16'h0000);
    rd_chk(21'h008020, 16'h2222);
    chk({14'h0000, mode}, 16'h0000);
    op(OP_AUTOSEL, 21'h000000, 16'h0000);
    op(OP_RESET, 21'h000000, 16'h0000);
    chk({14'h0000, mode}, 16'h0000);
    op(OP_ID_READ, 21'h008020, 16'h0000);
    chk(rd, 16'h2222);
    op(OP_CFI, 21'h000000, 16'h0000);
    chk({14'h0000, mode}, 16'h0002);
    op(OP_ID_READ, 21'h000010, 16'h0000);
    chk(rd, 16'h0051);
    rd_chk(21'h008020, 16'h2222);
  endtask : t_ident
  task automatic t_error();
    @(posedge clk) fail_next <= 1'b1;
    op(OP_PROGRAM, 21'h008020, 16'h0F0F);
    @(posedge clk) fail_next <= 1'b0;
    poll(21'h008020);
    chk({15'h0000, err_flag}, 16'h0001);
    rd_chk(21'h008020, 16'h2222);
  endtask : t_error
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    @(posedge clk) powered <= 1'b1;
    t_program();
    t_bypass();
    t_erase();
    t_suspend();
    t_ident();
    t_error();
    final_report();
  end
endmodule : fcs_sequencer_tb
`default_nettype wire
